// file: hdl/asq_pkg.sv
// Shared constants and carriers for the arithmetic step sequencer
`default_nettype none
package asq_pkg;
  // Timing: the alpha advance pulse comes from a divider of core_clk
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned ALPHA_NS = 160;
  localparam int unsigned ALPHA_CYC = (ALPHA_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] ALPHA_LAST = 4'(ALPHA_CYC - 1);
  localparam logic [3:0] DIV_RST = 4'h0;

  // Sequencer time levels, one flip-flop each
  localparam int unsigned NSTATE = 12;
  localparam int unsigned S00 = 0;
  localparam int unsigned S01 = 1;
  localparam int unsigned S02 = 2;
  localparam int unsigned S03 = 3;
  localparam int unsigned S04 = 4;
  localparam int unsigned S05 = 5;
  localparam int unsigned S06 = 6;
  localparam int unsigned S07 = 7;
  localparam int unsigned S08 = 8;
  localparam int unsigned S09 = 9;
  localparam int unsigned S10 = 10;
  localparam int unsigned S11 = 11;
  localparam logic [11:0] SEQ_IDLE = 12'h001;

  // Step counter
  localparam int unsigned STEP_W = 8;
  localparam int unsigned STEP_SIGN = 7;
  localparam logic [7:0] STEP_RST = 8'h00;

  // Register offsets
  localparam logic [3:0] OFS_OP = 4'h0;
  localparam logic [3:0] OFS_CFG = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_STEP = 4'hC;

  // Operation codes held in the op holder
  localparam logic [3:0] OPC_NONE = 4'h0;
  localparam logic [3:0] OPC_ADD = 4'h1;
  localparam logic [3:0] OPC_MINUS = 4'h2;
  localparam logic [3:0] OPC_PRODUCT = 4'h3;
  localparam logic [3:0] OPC_QUOTIENT = 4'h4;
  localparam logic [3:0] OPC_TALLY = 4'h5;
  localparam logic [3:0] OPC_JUSTIFY = 4'h6;
  localparam logic [3:0] OPC_BITMOVE = 4'h7;
  localparam logic [3:0] OPC_DISPATCH = 4'h8;

  // Config fields: [5:0] longest subword, [6] double length, [7] long carry
  localparam int unsigned CFG_LEN_LSB = 0;
  localparam int unsigned CFG_DBL = 6;
  localparam int unsigned CFG_LONG = 7;
  localparam logic [7:0] CFG_RST = 8'h09;
  localparam int unsigned STAT_BUSY = 12;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } asq_bus_t;

  typedef struct packed {
    logic start;
    logic preset;
    logic au_stop;
    logic operand_zero;
    logic all_justified;
    logic moves_done;
  } asq_ctl_t;
endpackage
`default_nettype wire

// file: hdl/asq_top.sv
// Arithmetic step sequencer: shift-register time levels and step counter
// Notes on behaviour
// RQ1: Shift register; flip-flops are the time levels.
// RQ2: Op load, preset, stop, bad op: idle.
// RQ3: Clear at 09 add/minus/product, 11 quotient, 03 dispatch.
// RQ4: Tally clears in 02 at step zero.
// RQ5: Justify clears in 04 on zero/normalized.
// RQ6: Bit-move clears in 04 when counts exhausted.
// RQ7: Start leaves idle, advances until wait/idle.
// RQ8: Justify and bit-move hold in 04.
// RQ9: Dispatch runs to 03 then idle.
// RQ10: Quotient/tally suppress advance in listed states.
// RQ11: Jump path never loads idle.
// RQ12: Add/minus jump 03 to 05/06 by length.
// RQ13: Product holds 03, then jumps 05/06.
// RQ14: Quotient loops 05..09, exits 08 to 10, 11.
// RQ15: Step cleared at start, preset negative in 01.
// RQ16: One step pulse per subcycle; sign ends.
// RQ17: Justify/bit-move count while holding 04.
// RQ18: Product counts once in 02, then per 03.
// RQ19: Tally counts each pass in 02.
// RQ20: Quotient counts each pass through 07.
// RQ21: All changes on the alpha enable pulse.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`default_nettype none
module asq_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire asq_pkg::asq_bus_t bus,
  output logic [31:0] rdata,
  input wire asq_pkg::asq_ctl_t ctl,
  output logic [11:0] time_levels,
  output logic [7:0] step_count,
  output logic step_pulse,
  output logic alpha_pulse
);
  import asq_pkg::*;

  logic [3:0] div_r;
  logic alpha_en;
  logic [3:0] op_r;
  logic op_pend_r;
  logic [7:0] cfg_r;
  logic [11:0] seq_r;
  logic [11:0] seq_nxt;
  logic [7:0] step_r;
  logic [7:0] step_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic step_pl_r;
  logic is_add;
  logic is_prod;
  logic is_quot;
  logic is_tally;
  logic is_just;
  logic is_move;
  logic is_disp;
  logic op_bad;
  logic force_idle;
  logic idle;
  logic end_clr;
  logic jump_hit;
  logic [11:0] jump_tgt;
  logic hold;
  logic inhibit;
  logic count_en;
  logic step_zero;
  logic step_done;
  logic [7:0] preset_val;
  logic [6:0] len_eff;

  // One-hot image of a single level
  function automatic logic [11:0] lvl(input int unsigned idx);
    lvl = 12'h001 << idx;
  endfunction

  // Carry stage entry; a long subword enters earlier to allow more carry time
  function automatic logic [11:0] carry_entry(input logic long_sel);
    carry_entry = long_sel ? lvl(S05) : lvl(S06);
  endfunction

  // Alpha divider; one-cycle enable per alpha period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= DIV_RST;
    end else if (div_r == ALPHA_LAST) begin
      div_r <= DIV_RST;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
  assign alpha_en = (div_r == ALPHA_LAST);

  // Op holder; a write loads at once and marks a pending load that forces idle on alpha
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= OPC_NONE;
    end else if (bus.wr && bus.addr == OFS_OP) begin
      op_r <= bus.wdata[3:0];
    end
  end

  // Pending load flag: a new write wins over the alpha clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_pend_r <= 1'b0;
    end else if (bus.wr && bus.addr == OFS_OP) begin
      op_pend_r <= 1'b1;
    end else if (alpha_en) begin
      op_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RST;
    end else if (bus.wr && bus.addr == OFS_CFG) begin
      cfg_r <= bus.wdata[7:0];
    end
  end

  // Operation decode
  assign is_add = (op_r == OPC_ADD) || (op_r == OPC_MINUS);
  assign is_prod = (op_r == OPC_PRODUCT);
  assign is_quot = (op_r == OPC_QUOTIENT);
  assign is_tally = (op_r == OPC_TALLY);
  assign is_just = (op_r == OPC_JUSTIFY);
  assign is_move = (op_r == OPC_BITMOVE);
  assign is_disp = (op_r == OPC_DISPATCH);
  assign op_bad = !(is_add || is_prod || is_quot || is_tally || is_just || is_move || is_disp);

  assign idle = seq_r[S00];
  assign step_zero = (step_r == STEP_RST);
  // RQ16: sign bit clear ends count
  assign step_done = !step_r[STEP_SIGN];

  // RQ15: negative preset from longest subword, doubled for double length
  assign len_eff = cfg_r[CFG_DBL] ? {cfg_r[5:0], 1'b0} : {1'b0, cfg_r[5:0]};
  assign preset_val = 8'h00 - {1'b0, len_eff};

  // RQ2: forced idle sources
  assign force_idle = op_pend_r || ctl.preset || ctl.au_stop || op_bad;

  // RQ3: end of instruction clears
  always_comb begin
    end_clr = 1'b0;
    if (is_add || is_prod) begin
      end_clr = seq_r[S09];
    end else if (is_quot) begin
      end_clr = seq_r[S11];
    end else if (is_disp) begin
      // RQ9: dispatch ends at 03
      end_clr = seq_r[S03];
    end else if (is_tally) begin
      // RQ4: tally ends in 02
      end_clr = seq_r[S02] && step_zero;
    end else if (is_just) begin
      // RQ5: zero operand or all normalized
      end_clr = seq_r[S04] &&
        ((ctl.operand_zero && step_zero) || (!ctl.operand_zero && ctl.all_justified));
    end else if (is_move) begin
      // RQ6: clear after all counts done
      end_clr = seq_r[S04] && ctl.moves_done;
    end
  end

  // Forward and backward jumps; targets are never the idle level
  always_comb begin
    jump_hit = 1'b0;
    jump_tgt = lvl(S05);
    if (is_add && seq_r[S03]) begin
      // RQ12: carry time by subword length
      jump_hit = 1'b1;
      jump_tgt = carry_entry(cfg_r[CFG_LONG]);
    end else if (is_prod && seq_r[S03] && step_done) begin
      // RQ13: final carry after steps
      jump_hit = 1'b1;
      jump_tgt = carry_entry(cfg_r[CFG_LONG]);
    end else if (is_quot && (seq_r[S02] || seq_r[S09])) begin
      // RQ14: enter or re-enter divide loop
      jump_hit = 1'b1;
      jump_tgt = carry_entry(cfg_r[CFG_LONG]);
    end else if (is_quot && seq_r[S08]) begin
      // RQ14: leave loop to 10 on finish
      jump_hit = 1'b1;
      jump_tgt = (step_done && step_r[2] && !step_r[1]) ? lvl(S10) : lvl(S09);
    end
  end

  // RQ8: waiting states hold the level
  assign hold = ((is_just || is_move) && seq_r[S04]) ||
    (is_prod && seq_r[S03] && !step_done);

  // RQ10: quotient and tally suppress the plain advance
  assign inhibit = (is_quot || is_tally) &&
    (seq_r[S02] || seq_r[S03] || seq_r[S09] || seq_r[S11] ||
     (seq_r[S08] && (step_r[STEP_SIGN] || (step_r[2] && !step_r[1]))));

  // Step pulse per subcycle pass
  always_comb begin
    count_en = 1'b0;
    if (is_prod) begin
      // RQ18: once in 02, then per 03 pass
      count_en = seq_r[S02] || (seq_r[S03] && !step_done);
    end else if (is_tally) begin
      // RQ19: each pass in 02
      count_en = seq_r[S02] && !step_zero;
    end else if (is_just || is_move) begin
      // RQ17: counts while holding 04
      count_en = seq_r[S04] && !end_clr;
    end else if (is_quot) begin
      // RQ20: each pass through 07
      count_en = seq_r[S07];
    end
  end

  // Next level of the shift register
  always_comb begin
    seq_nxt = seq_r;
    if (force_idle) begin
      seq_nxt = SEQ_IDLE;
    end else if (idle) begin
      // RQ7: start leaves idle
      if (ctl.start) begin
        seq_nxt = lvl(S01);
      end
    end else if (end_clr) begin
      seq_nxt = SEQ_IDLE;
    end else if (jump_hit) begin
      // RQ11: jump target from non-idle set
      seq_nxt = jump_tgt;
    end else if (!hold && !inhibit) begin
      // RQ1: plain shift to the next level
      seq_nxt = {seq_r[10:0], seq_r[11]};
    end
  end

  always_comb begin
    step_nxt = step_r;
    if (force_idle) begin
      step_nxt = step_r;
    end else if (idle && ctl.start) begin
      // RQ15: cleared on start
      step_nxt = STEP_RST;
    end else if (seq_r[S01]) begin
      step_nxt = preset_val;
    end else if (count_en) begin
      step_nxt = step_r + 8'h01;
    end
  end

  // RQ21: sequencer advances only on alpha
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= SEQ_IDLE;
    end else if (alpha_en) begin
      seq_r <= seq_nxt;
    end
  end

  // RQ21: step counter moves only on alpha
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_r <= STEP_RST;
    end else if (alpha_en) begin
      step_r <= step_nxt;
    end
  end

  // RQ16: registered step pulse, one cycle per counted pass
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_pl_r <= 1'b0;
    end else begin
      step_pl_r <= alpha_en && !force_idle && !idle && !seq_r[S01] && count_en;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (bus.addr)
      OFS_OP: rdata_nxt = {28'h000_0000, op_r};
      OFS_CFG: rdata_nxt = {24'h00_0000, cfg_r};
      OFS_STAT: rdata_nxt = {19'h0_0000, !idle, seq_r};
      OFS_STEP: rdata_nxt = {24'h00_0000, step_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_r;
  assign time_levels = seq_r;
  assign step_count = step_r;
  assign step_pulse = step_pl_r;
  assign alpha_pulse = alpha_en;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_onehot_levels: assert property ($onehot(seq_r)) // RQ1
    else $error("time levels not one-hot");

  a_force_idle_now: assert property (alpha_en && force_idle |=> seq_r == SEQ_IDLE) // RQ2
    else $error("forced idle not taken");

  a_end_at_nine: assert property (
    alpha_en && !force_idle && (is_add || is_prod) && seq_r[S09] |=> seq_r[S00]) // RQ3
    else $error("add/product did not clear at 09");

  a_tally_end: assert property (
    alpha_en && !force_idle && is_tally && seq_r[S02] && step_zero |=> seq_r[S00]) // RQ4
    else $error("tally did not clear in 02");

  a_start_leaves: assert property (
    alpha_en && !force_idle && idle && ctl.start |=> seq_r[S01] && step_r == STEP_RST) // RQ7
    else $error("start did not leave idle");

  a_jump_nonidle: assert property (
    alpha_en && !force_idle && !idle && !end_clr && jump_hit |=> !seq_r[S00]) // RQ11
    else $error("jump loaded idle");

  a_carry_jump: assert property (
    alpha_en && !force_idle && is_add && seq_r[S03] |=> seq_r[S05] || seq_r[S06]) // RQ12
    else $error("add/minus did not jump to carry");

  a_product_hold: assert property (
    alpha_en && !force_idle && is_prod && seq_r[S03] && !step_done |=> seq_r[S03]) // RQ13
    else $error("product left 03 early");

  a_step_preset: assert property (
    alpha_en && !force_idle && seq_r[S01] |=> step_r == $past(preset_val)) // RQ15
    else $error("step preset wrong");

  a_alpha_only: assert property (
    !alpha_en |=> $stable(seq_r) && $stable(step_r)) // RQ21
    else $error("state moved off alpha");

  a_hold_four: assert property (
    alpha_en && !force_idle && is_move && seq_r[S04] && !ctl.moves_done
    |=> seq_r[S04] && step_r == $past(step_r) + 8'h01) // RQ17
    else $error("bit-move left 04 or did not count");

  a_quot_exit: assert property (
    alpha_en && !force_idle && is_quot && seq_r[S08] && step_done && step_r[2] && !step_r[1]
    |=> seq_r[S10] ##[1:4] seq_r[S11]) // RQ14
    else $error("quotient did not exit to 10 then 11");

  a_dispatch_end: assert property (
    alpha_en && !force_idle && is_disp && seq_r[S03] |=> seq_r[S00]) // RQ9
    else $error("dispatch did not clear at 03");

  a_quot_end: assert property (
    alpha_en && !force_idle && is_quot && seq_r[S11] |=> seq_r[S00]) // RQ3
    else $error("quotient did not clear at 11");

  a_tally_stall: assert property (
    alpha_en && !force_idle && is_tally && seq_r[S02] && !step_zero
    |=> seq_r[S02] && step_r == $past(step_r) + 8'h01) // RQ10
    else $error("tally left 02 or did not count");

  a_justify_hold: assert property (
    alpha_en && !force_idle && is_just && seq_r[S04] && !end_clr |=> seq_r[S04]) // RQ8
    else $error("justify left 04 early");

  a_quot_count: assert property (
    alpha_en && !force_idle && is_quot && seq_r[S07] |=> step_r == $past(step_r) + 8'h01) // RQ20
    else $error("quotient did not count in 07");
endmodule
`default_nettype wire

// file: verif/asq_ctl_model.sv
// Far-side cycle control and datapath status model
`default_nettype none
module asq_ctl_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [4:0] cond,
  input wire logic [11:0] time_levels,
  output var asq_pkg::asq_ctl_t ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  import asq_pkg::*;
  logic start_r;
  logic left_r;
  // start held only until levels leave idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_r <= 1'b0;
      left_r <= 1'b0;
    end else begin
      left_r <= go & (left_r | ~time_levels[S00]);
      start_r <= go & ~left_r & time_levels[S00];
    end
  end
  // Status levels pass straight through, no cleanup
  assign ctl = {start_r, cond};
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking testbench for the arithmetic step sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asq_pkg::*;
  logic core_clk, rst_n, go, step_pulse, alpha_pulse, al1;
  logic [4:0] cond;
  logic [31:0] rdata;
  logic [11:0] time_levels, lv1;
  logic [7:0] step_count, pre, st1, st2;
  logic [63:0] seq;
  asq_bus_t bus;
  asq_ctl_t ctl;
  int mismatches = 0;
  int checked = 0;

  asq_top i_asq_top (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .ctl(ctl), .time_levels(time_levels), .step_count(step_count),
    .step_pulse(step_pulse), .alpha_pulse(alpha_pulse));
  asq_ctl_model i_asq_ctl_model (.core_clk(core_clk), .rst_n(rst_n), .go(go),
    .cond(cond), .time_levels(time_levels), .ctl(ctl));

  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    @(negedge core_clk);
    chk($sformatf("reg %h", a), 64'(e), 64'(rdata));
  endtask

  // Collapsed trace of visited levels, one nibble per level
  task automatic run(input logic [3:0] op, input logic [7:0] cfg, input logic [4:0] c,
      input int lim);
    int n;
    logic [3:0] idx;
    seq = '0;
    pre = 8'h00;
    n = 0;
    wr(OFS_CFG, {24'h0, cfg});
    wr(OFS_OP, {28'h0, op});
    cond <= c;
    go <= 1'b1;
    do begin
      @(negedge core_clk);
      n++;
      idx = 4'h0;
      for (int i = 0; i < NSTATE; i++) if (time_levels[i]) idx = 4'(i);
      if (idx != seq[3:0]) begin
        seq = {seq[59:0], idx};
        if (idx == 4'h2) pre = step_count;
      end
    end while (n < lim && !(idx == 4'h0 && seq != '0));
    @(posedge core_clk);
    go <= 1'b0;
  endtask

  task automatic one(input logic [3:0] op, input logic [7:0] cfg, input logic [4:0] c,
      input logic [63:0] e, input logic [63:0] m, input logic [7:0] p, input int es);
    run(op, cfg, c, 3000);
    chk("level trace", e, seq & m);
    chk("step preset", 64'(p), 64'(pre));
    if (es >= 0) chk("final step", 64'(es), 64'(step_count));
    cond <= 5'h00;
    $display("Done op %h cfg %h", op, cfg);
  endtask

  task automatic hold(input logic [3:0] op, input logic [4:0] c);
    int n;
    run(op, 8'h09, 5'h00, 200);
    chk("hold trace", 64'h1234, seq);
    chk("step moving", 64'd1, 64'(step_count !== 8'hF7));
    rdc(OFS_STAT, 32'h1010);
    @(posedge core_clk);
    cond <= c;
    n = 0;
    while (time_levels !== SEQ_IDLE && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk("hold release", 64'(SEQ_IDLE), 64'(time_levels));
    cond <= 5'h00;
    $display("Done hold op %h", op);
  endtask

  task automatic abort(input int k);
    int n;
    wr(OFS_CFG, 32'h09);
    wr(OFS_OP, {28'h0, OPC_PRODUCT});
    go <= 1'b1;
    n = 0;
    while (time_levels[S03] !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    go <= 1'b0;
    if (k == 2) wr(OFS_OP, {28'h0, OPC_PRODUCT});
    else cond <= (k == 0) ? 5'h10 : 5'h08;
    repeat (9) @(negedge core_clk);
    chk("forced idle", 64'(SEQ_IDLE), 64'(time_levels));
    @(posedge core_clk);
    cond <= 5'h00;
    $display("Done abort %0d", k);
  endtask

  task automatic regs;
    rdc(OFS_OP, 32'h0);
    rdc(OFS_CFG, 32'h09);
    rdc(OFS_STAT, 32'h001);
    rdc(OFS_STEP, 32'h0);
    wr(4'h2, 32'hFFFFFFFF);
    rdc(4'h2, 32'h0);
    rdc(OFS_CFG, 32'h09);
    wr(OFS_CFG, 32'hFFFFFFAB);
    rdc(OFS_CFG, 32'hAB);
    $display("Done registers");
  endtask

  task automatic conclude;
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watch levels and counts every cycle, mid-cycle where settled
  always @(negedge core_clk) begin
    if (rst_n === 1'b1) begin
      chk("one-hot", 64'd1, 64'($onehot(time_levels)));
      if (time_levels !== lv1) chk("alpha move", 64'd1, 64'(al1));
      if (step_pulse === 1'b1) chk("step pulse", 64'(8'(st1 + 8'h01)), 64'(step_count));
    end
    lv1 = time_levels;
    al1 = alpha_pulse;
    st2 = st1;
    st1 = step_count;
  end

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    cond = 5'h00;
    bus = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    regs();
    one(OPC_ADD, 8'h09, 5'h00, 64'h12367890, '1, 8'hF7, -1);
    one(OPC_ADD, 8'h89, 5'h00, 64'h123567890, '1, 8'hF7, -1);
    one(OPC_MINUS, 8'h49, 5'h00, 64'h12367890, '1, 8'hEE, -1);
    one(OPC_PRODUCT, 8'h09, 5'h00, 64'h12367890, '1, 8'hF7, -1);
    one(OPC_QUOTIENT, 8'h89, 5'h00, 64'h8AB0, 64'hFFFF, 8'hF7, -1);
    one(OPC_TALLY, 8'h09, 5'h00, 64'h120, '1, 8'hF7, 0);
    one(OPC_DISPATCH, 8'h09, 5'h00, 64'h1230, '1, 8'hF7, -1);
    one(OPC_JUSTIFY, 8'h09, 5'h04, 64'h12340, '1, 8'hF7, 0);
    one(4'hF, 8'h09, 5'h00, 64'h0, '1, 8'h00, -1);
    hold(OPC_JUSTIFY, 5'h02);
    hold(OPC_BITMOVE, 5'h01);
    for (int k = 0; k < 3; k++) abort(k);
    conclude();
  end

  initial begin
    #(40 * 30000);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
